// *** rtl/shrm_pkg.sv ***
`default_nettype none
package shrm_pkg;
   // direct space, byte addresses
   localparam logic [7:0] OFS_PRIO_Q0 = 8'h00;
   localparam logic [7:0] OFS_PRIO_Q1 = 8'h04;
   localparam logic [7:0] OFS_PRIO_Q2 = 8'h08;
   localparam logic [7:0] OFS_PRIO_Q3 = 8'h0c;
   localparam logic [7:0] OFS_CTL_Q0_HEAD = 8'h18;
   localparam logic [7:0] OFS_CTL_Q1_HEAD = 8'h1c;
   localparam logic [7:0] OFS_QUEUE_IRQ = 8'h20;
   localparam logic [7:0] OFS_TIMER_IRQ = 8'h24;
   localparam logic [7:0] OFS_IO_CTRL_IRQ = 8'h28;
   localparam logic [7:0] OFS_SUMMARY_IRQ = 8'h2c;
   localparam logic [7:0] OFS_IND_INDEX = 8'h30;
   localparam logic [7:0] OFS_IND_DATA = 8'h34;
   localparam logic [7:0] OFS_CTL_Q1_DONE = 8'h38;
   localparam logic [7:0] OFS_CTL_Q0_DONE = 8'h3c;

   // reset values
   localparam logic [15:0] RST_QUEUE_IRQ = 16'h7f00;
   localparam logic [15:0] RST_STATUS = 16'h0000;
   localparam logic [15:0] RST_IND_INDEX = 16'h0000;
   localparam logic [15:0] RST_DONE = 16'h0000;
   localparam logic [15:0] RST_HOST_CONTROL = 16'h6200;

   // secondary space, register indices
   localparam logic [15:0] IND_HOST_CONTROL = 16'h0000;
   localparam logic [15:0] IND_PROTOCOL_TYPE = 16'h0001;
   localparam logic [15:0] IND_REVISION_ID = 16'h0002;
   localparam logic [15:0] IND_PART_ID = 16'h0003;
   localparam logic [15:0] IND_VENDOR_ID = 16'h0004;

   // queue slots: four priority queues, then the two host-controlled ones
   localparam int NUM_PRIO_Q = 4;
   localparam int NUM_Q = 6;
   localparam int SLOT_CTL_Q0 = 4;
   localparam int SLOT_CTL_Q1 = 5;
   localparam int REG_W = 16;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } shrm_apb_req_t;
endpackage : shrm_pkg
`default_nettype wire

// *** rtl/shrm_swap.sv ***
`default_nettype none
// reverses byte order; the same network serves swap and unswap
module shrm_swap #(
   parameter int W = 16
) (
   input wire logic [W-1:0] din, // word in
   output logic [W-1:0] dout // word with bytes reversed
);
   if (W % 8 != 0) begin : g_chk
      $error("shrm_swap: width must be whole bytes");
   end
   for (genvar b = 0; b < W / 8; b++) begin : g_byte
      assign dout[8*b +: 8] = din[W-8-8*b +: 8];
   end
endmodule : shrm_swap
`default_nettype wire

// *** rtl/shrm_ind_bank.sv ***
`default_nettype none
module shrm_ind_bank #(
   parameter logic [15:0] PROTOCOL = 16'h0000, // stands in for strap value
   parameter logic [15:0] REVISION = 16'h0a0a, // arbitrary value
   parameter logic [15:0] PART = 16'h0b0b, // arbitrary value
   parameter logic [15:0] VENDOR = 16'h0c0c // arbitrary value
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic wr, // write strobe for the indexed register
   input wire logic [15:0] index, // selected register
   input wire logic [15:0] wdata, // unswapped write data
   output logic [15:0] rdata, // indexed register contents
   output logic [15:0] host_control // host control register
);
   typedef struct packed {
      logic [15:0] host_control;
   } shrm_ind_state_t;

   shrm_ind_state_t s_reg;
   shrm_ind_state_t s_next;

   always_comb begin
      s_next = s_reg;
      if (wr && index == shrm_pkg::IND_HOST_CONTROL) begin
         s_next.host_control = wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '{host_control: shrm_pkg::RST_HOST_CONTROL};
      end else begin
         s_reg <= s_next;
      end
   end

   // unused indices read zero, writes to read-only ones are dropped
   always_comb begin
      case (index)
         shrm_pkg::IND_HOST_CONTROL: rdata = s_reg.host_control;
         shrm_pkg::IND_PROTOCOL_TYPE: rdata = PROTOCOL;
         shrm_pkg::IND_REVISION_ID: rdata = REVISION;
         shrm_pkg::IND_PART_ID: rdata = PART;
         shrm_pkg::IND_VENDOR_ID: rdata = VENDOR;
         default: rdata = 16'h0000;
      endcase
   end

   assign host_control = s_reg.host_control;
endmodule : shrm_ind_bank
`default_nettype wire

// *** rtl/shrm_top.sv ***
`default_nettype none
module shrm_top #(
   parameter int QW = 32, // queue word width, 16 or 32
   parameter logic [15:0] PROTOCOL = 16'h0000, // stands in for strap value
   parameter logic [15:0] REVISION = 16'h0a0a, // arbitrary value
   parameter logic [15:0] PART = 16'h0b0b, // arbitrary value
   parameter logic [15:0] VENDOR = 16'h0c0c // arbitrary value
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, always low
   input wire logic [shrm_pkg::NUM_Q-1:0][QW-1:0] rxq_data, // receive words
   input wire logic [shrm_pkg::NUM_Q-1:0] rxq_valid, // receive word present
   output logic [shrm_pkg::NUM_Q-1:0] rxq_ready, // receive word taken
   output logic [shrm_pkg::NUM_Q-1:0][QW-1:0] txq_data, // transmit words
   output logic [shrm_pkg::NUM_Q-1:0] txq_valid, // transmit word present
   input wire logic [shrm_pkg::NUM_Q-1:0] txq_ready, // transmit word taken
   input wire logic [15:0] queue_status_in, // live queue status
   input wire logic [15:0] timer_evt, // timer event pulses
   input wire logic [15:0] io_ctrl_evt, // io controller event pulses
   input wire logic [15:0] summary_evt, // summary event pulses
   output logic [15:0] host_control // secondary host control register
);
   localparam int NQ = shrm_pkg::NUM_Q;
   localparam int RW = shrm_pkg::REG_W;

   if (QW != 16 && QW != 32) begin : g_chk_width
      $error("shrm_top: queue width must be 16 or 32");
   end

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic [NQ-1:0] rx_ready;
      logic [NQ-1:0] tx_valid;
      logic [NQ-1:0][QW-1:0] tx_data;
      logic [15:0] queue_irq;
      logic [15:0] timer_irq;
      logic [15:0] io_ctrl_irq;
      logic [15:0] summary_irq;
      logic [15:0] ind_index;
      logic [15:0] q0_done;
      logic [15:0] q1_done;
   } shrm_state_t;

   shrm_state_t s_reg;
   shrm_state_t s_next;
   shrm_pkg::shrm_apb_req_t req;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};

   // access phase not yet answered
   logic access;
   assign access = req.psel && req.penable && !s_reg.pready;

   // queue slot decode: q_hit low when the offset is not a queue port
   logic q_hit;
   logic [2:0] q_slot;

   always_comb begin
      q_hit = 1'b1;
      q_slot = 3'd0;
      case (req.paddr)
         shrm_pkg::OFS_PRIO_Q0: q_slot = 3'd0;
         shrm_pkg::OFS_PRIO_Q1: q_slot = 3'd1;
         shrm_pkg::OFS_PRIO_Q2: q_slot = 3'd2;
         shrm_pkg::OFS_PRIO_Q3: q_slot = 3'd3;
         shrm_pkg::OFS_CTL_Q0_HEAD:
            q_slot = 3'(shrm_pkg::SLOT_CTL_Q0);
         shrm_pkg::OFS_CTL_Q1_HEAD:
            q_slot = 3'(shrm_pkg::SLOT_CTL_Q1);
         default: q_hit = 1'b0;
      endcase
   end

   // memory path: swap on the way in and out
   logic [QW-1:0] rx_sel;
   logic [QW-1:0] rx_swapped;
   logic [QW-1:0] tx_swapped;

   assign rx_sel = rxq_data[q_slot];

   shrm_swap #(.W(QW)) u_rx_swap (
      .din(rx_sel),
      .dout(rx_swapped)
   );

   shrm_swap #(.W(QW)) u_tx_swap (
      .din(req.pwdata[QW-1:0]),
      .dout(tx_swapped)
   );

   // register path: swap on read, unswap on write
   logic [RW-1:0] reg_rd;
   logic [RW-1:0] reg_rd_swapped;
   logic [RW-1:0] reg_wr_unswapped;
   logic [15:0] ind_rdata;

   always_comb begin
      case (req.paddr)
         shrm_pkg::OFS_QUEUE_IRQ: reg_rd = s_reg.queue_irq;
         shrm_pkg::OFS_TIMER_IRQ: reg_rd = s_reg.timer_irq;
         shrm_pkg::OFS_IO_CTRL_IRQ: reg_rd = s_reg.io_ctrl_irq;
         shrm_pkg::OFS_SUMMARY_IRQ: reg_rd = s_reg.summary_irq;
         shrm_pkg::OFS_IND_INDEX: reg_rd = s_reg.ind_index;
         shrm_pkg::OFS_IND_DATA: reg_rd = ind_rdata;
         shrm_pkg::OFS_CTL_Q1_DONE: reg_rd = s_reg.q1_done;
         shrm_pkg::OFS_CTL_Q0_DONE: reg_rd = s_reg.q0_done;
         default: reg_rd = 16'h0000;
      endcase
   end

   shrm_swap #(.W(RW)) u_reg_rd_swap (
      .din(reg_rd),
      .dout(reg_rd_swapped)
   );

   shrm_swap #(.W(RW)) u_reg_wr_swap (
      .din(req.pwdata[RW-1:0]),
      .dout(reg_wr_unswapped)
   );

   // secondary space
   logic ind_wr;
   assign ind_wr = access && req.pwrite
                   && req.paddr == shrm_pkg::OFS_IND_DATA;

   shrm_ind_bank #(
      .PROTOCOL(PROTOCOL),
      .REVISION(REVISION),
      .PART(PART),
      .VENDOR(VENDOR)
   ) u_ind_bank (
      .pclk(pclk),
      .presetn(presetn),
      .wr(ind_wr),
      .index(s_reg.ind_index),
      .wdata(reg_wr_unswapped),
      .rdata(ind_rdata),
      .host_control(host_control)
   );

   // transmit handshakes completing this cycle
   logic [NQ-1:0] tx_taken;
   assign tx_taken = s_reg.tx_valid & txq_ready;

   always_comb begin
      s_next = s_reg;
      s_next.pready = 1'b0;
      s_next.rx_ready = '0;
      s_next.tx_valid = s_reg.tx_valid & ~tx_taken;
      s_next.queue_irq = queue_status_in;
      // hardware events are sticky until software writes ones to clear
      s_next.timer_irq = s_reg.timer_irq | timer_evt;
      s_next.io_ctrl_irq = s_reg.io_ctrl_irq | io_ctrl_evt;
      s_next.summary_irq = s_reg.summary_irq | summary_evt;
      if (tx_taken[shrm_pkg::SLOT_CTL_Q0]) begin
         s_next.q0_done = s_reg.q0_done + 16'h0001;
      end
      if (tx_taken[shrm_pkg::SLOT_CTL_Q1]) begin
         s_next.q1_done = s_reg.q1_done + 16'h0001;
      end

      if (access) begin
         s_next.pready = 1'b1;
         s_next.prdata = 32'h0000_0000;
         if (q_hit) begin
            if (req.pwrite) begin
               // full slot: hold pready low until the sink drains it
               if (s_reg.tx_valid[q_slot] && !txq_ready[q_slot]) begin
                  s_next.pready = 1'b0;
               end else begin
                  s_next.tx_valid[q_slot] = 1'b1;
                  s_next.tx_data[q_slot] = tx_swapped;
               end
            end else if (rxq_valid[q_slot]) begin
               // empty queue reads zero and pops nothing
               s_next.prdata[QW-1:0] = rx_swapped;
               s_next.rx_ready[q_slot] = 1'b1;
            end
         end else if (!req.pwrite) begin
            s_next.prdata[RW-1:0] = reg_rd_swapped;
         end else begin
            case (req.paddr)
               shrm_pkg::OFS_TIMER_IRQ: begin
                  s_next.timer_irq = (s_reg.timer_irq & ~reg_wr_unswapped)
                                     | timer_evt;
               end
               shrm_pkg::OFS_IO_CTRL_IRQ: begin
                  s_next.io_ctrl_irq =
                     (s_reg.io_ctrl_irq & ~reg_wr_unswapped)
                     | io_ctrl_evt;
               end
               shrm_pkg::OFS_SUMMARY_IRQ: begin
                  s_next.summary_irq =
                     (s_reg.summary_irq & ~reg_wr_unswapped)
                     | summary_evt;
               end
               shrm_pkg::OFS_IND_INDEX: begin
                  s_next.ind_index = reg_wr_unswapped;
               end
               // read-only and reserved offsets drop the write
               default: s_next.ind_index = s_reg.ind_index;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg.pready <= 1'b0;
         s_reg.prdata <= 32'h0000_0000;
         s_reg.rx_ready <= '0;
         s_reg.tx_valid <= '0;
         s_reg.tx_data <= '0;
         s_reg.queue_irq <= shrm_pkg::RST_QUEUE_IRQ;
         s_reg.timer_irq <= shrm_pkg::RST_STATUS;
         s_reg.io_ctrl_irq <= shrm_pkg::RST_STATUS;
         s_reg.summary_irq <= shrm_pkg::RST_STATUS;
         s_reg.ind_index <= shrm_pkg::RST_IND_INDEX;
         s_reg.q0_done <= shrm_pkg::RST_DONE;
         s_reg.q1_done <= shrm_pkg::RST_DONE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = 1'b0;
   assign rxq_ready = s_reg.rx_ready;
   assign txq_valid = s_reg.tx_valid;
   assign txq_data = s_reg.tx_data;
endmodule : shrm_top
`default_nettype wire

// *** test/shrm_chk_sva.sv ***
`default_nettype none
module shrm_chk #(
   parameter int QW = 32
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [7:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic [shrm_pkg::NUM_Q-1:0][QW-1:0] rxq_data, // rx words
   input wire logic [shrm_pkg::NUM_Q-1:0] rxq_valid, // rx present
   input wire logic [shrm_pkg::NUM_Q-1:0] rxq_ready, // rx pop
   input wire logic [shrm_pkg::NUM_Q-1:0][QW-1:0] txq_data, // tx words
   input wire logic [shrm_pkg::NUM_Q-1:0] txq_valid, // tx present
   input wire logic [shrm_pkg::NUM_Q-1:0] txq_ready // tx accept
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_end;
   assign rd_end = pready && !pwrite;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   function automatic logic [QW-1:0] sw(input logic [QW-1:0] v);
      return {<<8{v}};
   endfunction : sw
   chk_read_latency: assert property (
      psel && !pwrite && $rose(penable) |=> pready)
      else $error("read answer not one cycle after access");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_rx_prio: assert property (
      rd_end && paddr == shrm_pkg::OFS_PRIO_Q0 && rxq_valid[0]
      |-> prdata[QW-1:0] == sw(rxq_data[0]))
      else $error("queue 0 read word wrong");
   chk_rx_head: assert property (
      rd_end && paddr == shrm_pkg::OFS_CTL_Q1_HEAD && rxq_valid[5]
      |-> prdata[QW-1:0] == sw(rxq_data[5]))
      else $error("read head word wrong");
   chk_rx_pop: assert property (
      |rxq_ready |-> rd_end && (rxq_ready & ~rxq_valid) == '0)
      else $error("receive pop outside a read");
   chk_tx_hold: assert property (
      txq_valid[4] && !txq_ready[4]
      |=> txq_valid[4] && $stable(txq_data[4]))
      else $error("transmit word dropped while stalled");
   chk_tx_launch: assert property (
      $rose(txq_valid[4]) |-> pready && pwrite
      && paddr == shrm_pkg::OFS_CTL_Q0_HEAD
      && txq_data[4] == sw(pwdata[QW-1:0]))
      else $error("transmit word not from matching write");
   chk_rsv_read: assert property (
      rd_end && paddr == 8'h10 |-> prdata == 32'h00000000)
      else $error("reserved offset read not zero");
   chk_reg_upper: assert property (
      rd_end && paddr[5] |-> prdata[31:16] == 16'h0000)
      else $error("register upper half not zero");
   cv_tx_stall: cover property (txq_valid[4] && !txq_ready[4]);
   cv_rx_pop: cover property (rxq_ready[5]);
   cv_rsv: cover property (rd_end && paddr == 8'h10);
endmodule : shrm_chk
bind shrm_top shrm_chk #(.QW(QW)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .rxq_data(rxq_data), .rxq_valid(rxq_valid),
   .rxq_ready(rxq_ready), .txq_data(txq_data), .txq_valid(txq_valid),
   .txq_ready(txq_ready));
`default_nettype wire

// *** test/shrm_q_model.sv ***
`default_nettype none
module shrm_q_model #(
   parameter int QW = 32
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic stall, // hold off tx accept
   input wire logic [shrm_pkg::NUM_Q-1:0] rxq_ready, // rx pop
   output logic [shrm_pkg::NUM_Q-1:0][QW-1:0] rxq_data, // rx words
   output logic [shrm_pkg::NUM_Q-1:0] rxq_valid, // rx present
   input wire logic [shrm_pkg::NUM_Q-1:0][QW-1:0] txq_data, // tx words
   input wire logic [shrm_pkg::NUM_Q-1:0] txq_valid, // tx present
   output logic [shrm_pkg::NUM_Q-1:0] txq_ready, // tx accept
   output logic [shrm_pkg::NUM_Q-1:0][QW-1:0] tx_last, // last tx taken
   output logic [shrm_pkg::NUM_Q-1:0][7:0] tx_cnt // tx words taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [shrm_pkg::NUM_Q-1:0][1:0] popped;
   assign txq_ready = stall ? '0 : '1;
   // two words a slot; an empty slot shows junk so stale reads show
   always_comb begin
      for (int i = 0; i < shrm_pkg::NUM_Q; i++) begin
         rxq_valid[i] = popped[i] < 2'd2;
         rxq_data[i] = QW'(32'h81828300 + 32'(i * 16) + 32'(popped[i]));
         if (!rxq_valid[i]) rxq_data[i] = ~rxq_data[i];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         popped <= '0;
         tx_last <= '0;
         tx_cnt <= '0;
      end else begin
         for (int i = 0; i < shrm_pkg::NUM_Q; i++) begin
            if (rxq_ready[i] && rxq_valid[i]) begin
               popped[i] <= popped[i] + 2'd1;
            end
            if (txq_valid[i] && txq_ready[i]) begin
               tx_last[i] <= txq_data[i];
               tx_cnt[i] <= tx_cnt[i] + 8'h01;
            end
         end
      end
   end
endmodule : shrm_q_model
`default_nettype wire

// *** test/test_switch_host_register_map.sv ***
`default_nettype none
`define CHK(n, e, a) begin \
   check_count++; \
   if ((a) !== (e)) begin \
      err_total++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, a); \
   end \
end
module test_switch_host_register_map;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int QW = 32;
   localparam int NQ = shrm_pkg::NUM_Q;
   localparam logic [7:0] QOFS [6] = '{8'h00, 8'h04, 8'h08, 8'h0c,
      8'h18, 8'h1c};
   localparam logic [7:0] ZOFS [6] = '{8'h24, 8'h28, 8'h2c, 8'h30,
      8'h38, 8'h3c};
   localparam logic [15:0] IND_EXP [6] = '{16'h0000, 16'h0001, 16'h0a0b,
      16'h0c0d, 16'h0e0f, 16'h0000};
   logic pclk = 1'b0, presetn = 1'b0, stall = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic pready, pslverr;
   logic [15:0] qstat = 16'h7f00, host_control;
   logic [2:0][15:0] evt = '0;
   logic [NQ-1:0][QW-1:0] rxd, txd, tx_last;
   logic [NQ-1:0] rxv, rxr, txv, txr;
   logic [NQ-1:0][7:0] tx_cnt;
   int err_total = 0, check_count = 0;
   always #10 pclk = ~pclk;
   // id values are arbitrary
   shrm_top #(.QW(QW), .PROTOCOL(16'h0001), .REVISION(16'h0a0b),
      .PART(16'h0c0d), .VENDOR(16'h0e0f)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxq_data(rxd), .rxq_valid(rxv),
      .rxq_ready(rxr), .txq_data(txd), .txq_valid(txv), .txq_ready(txr),
      .queue_status_in(qstat), .timer_evt(evt[0]), .io_ctrl_evt(evt[1]),
      .summary_evt(evt[2]), .host_control(host_control));
   shrm_q_model #(.QW(QW)) u_q (.pclk(pclk), .presetn(presetn),
      .stall(stall), .rxq_ready(rxr), .rxq_data(rxd), .rxq_valid(rxv),
      .txq_data(txd), .txq_valid(txv), .txq_ready(txr),
      .tx_last(tx_last), .tx_cnt(tx_cnt));
   // narrow-queue build on the same bus runs in lockstep with uut
   logic [31:0] prdata16, q16;
   logic [NQ-1:0][15:0] rxd16, txd16, tx_last16;
   logic [NQ-1:0] rxv16, rxr16, txv16, txr16;
   shrm_top #(.QW(16)) uut_w16 (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata16),
      .pready(), .pslverr(), .rxq_data(rxd16), .rxq_valid(rxv16),
      .rxq_ready(rxr16), .txq_data(txd16), .txq_valid(txv16),
      .txq_ready(txr16), .queue_status_in(qstat), .timer_evt(evt[0]),
      .io_ctrl_evt(evt[1]), .summary_evt(evt[2]), .host_control());
   shrm_q_model #(.QW(16)) u_q16 (.pclk(pclk), .presetn(presetn),
      .stall(stall), .rxq_ready(rxr16), .rxq_data(rxd16),
      .rxq_valid(rxv16), .txq_data(txd16), .txq_valid(txv16),
      .txq_ready(txr16), .tx_last(tx_last16), .tx_cnt());
   function automatic logic [31:0] s16(input logic [15:0] v);
      return {16'h0000, v[7:0], v[15:8]};
   endfunction : s16
   function automatic logic [31:0] sw(input logic [31:0] v);
      return {<<8{v}};
   endfunction : sw
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait limit here: only the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      q16 = prdata16;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string n);
      logic [31:0] q;
      apb(1'b0, a, 32'h00000000, q);
      `CHK(n, e, q)
      `CHK("pslverr", 1'b0, pslverr)
   endtask : rd
   task automatic t_reset();
      `CHK("host_control", 16'h6200, host_control)
      rd(8'h20, s16(16'h7f00), "queue_irq");
      foreach (ZOFS[i]) rd(ZOFS[i], 32'h0, "zero");
   endtask : t_reset
   task automatic t_status();
      qstat <= 16'h1234;
      wr(8'h20, 32'h0000ffff);
      rd(8'h20, s16(16'h1234), "queue_irq_live");
      for (int k = 0; k < 3; k++) begin
         evt[k] <= 16'h00ff;
         @(posedge pclk);
         evt[k] <= 16'h0000;
         @(posedge pclk);
         rd(ZOFS[k], s16(16'h00ff), "irq_set");
         wr(ZOFS[k], s16(16'h000f));
         rd(ZOFS[k], s16(16'h00f0), "irq_clear");
      end
   endtask : t_status
   task automatic t_rx();
      for (int i = 0; i < NQ; i++) begin
         rd(QOFS[i], sw(32'h81828300 + 32'(i * 16)), "rx0");
         `CHK("rx16", s16(16'h8300 + 16'(i * 16)), q16)
         rd(QOFS[i], sw(32'h81828301 + 32'(i * 16)), "rx1");
         rd(QOFS[i], 32'h0, "rx_empty");
      end
   endtask : t_rx
   task automatic t_tx();
      logic [31:0] d;
      for (int i = 0; i < NQ; i++) begin
         d = 32'hc0d0e0f0 + 32'(i);
         wr(QOFS[i], d);
         `CHK("tx_word", sw(d), tx_last[i])
         `CHK("tx_count", 8'h01, tx_cnt[i])
         `CHK("tx16", {d[7:0], d[15:8]}, tx_last16[i])
      end
      rd(8'h3c, s16(16'h0001), "q0_done");
      rd(8'h38, s16(16'h0001), "q1_done");
      stall <= 1'b1;
      wr(8'h18, 32'h11111111);
      fork
         wr(8'h18, 32'h22334455);
         begin
            repeat (6) @(posedge pclk);
            stall <= 1'b0;
         end
      join
      @(posedge pclk);
      `CHK("tx_stalled", sw(32'h22334455), tx_last[4])
      rd(8'h3c, s16(16'h0003), "q0_done_stall");
   endtask : t_tx
   task automatic t_rsv();
      wr(8'h10, 32'hffffffff);
      wr(8'h14, 32'hffffffff);
      rd(8'h10, 32'h0, "rsv_read");
      `CHK("rsv_no_tx", 8'h01, tx_cnt[0])
      rd(8'h24, s16(16'h00f0), "rsv_no_side");
   endtask : t_rsv
   task automatic t_ind();
      rd(8'h34, s16(16'h6200), "ind_ctrl_rst");
      wr(8'h34, 32'h0000a55a);
      `CHK("host_control_wr", 16'h5aa5, host_control)
      rd(8'h34, 32'h0000a55a, "ind_ctrl_rd");
      for (int i = 1; i < 6; i++) begin
         wr(8'h30, s16(16'(i)));
         rd(8'h30, s16(16'(i)), "ind_index");
         rd(8'h34, s16(IND_EXP[i]), "ind_data");
      end
   endtask : t_ind
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_status();
      t_rx();
      t_tx();
      t_rsv();
      t_ind();
      print_verdict();
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      err_total++;
      print_verdict();
   end
endmodule : test_switch_host_register_map
`default_nettype wire
